// ### rtl/iofe_front_end.sv
//Behaviour
//- during local DMA acknowledge, strobes, direction and buffer enables are released.
//- standard board select is A4-A15 compare qualified by I/O request.
//- standard decode spans A4-A15, region of 16 bytes.
//- extended board select captured on START from match, M-IO, slot enable.
//- extended strobes come from W-R while latched select true during CMD.
//- I/O board decodes A0-A15 only; memory boards also decode upper address.
//- slot transfers ignore A12-A15, need A8/A9 low, decode the rest.
//- without slot enables, full 16-bit decode inside three permitted ranges.
//- internal address holds latched A2-A7 plus byte-enable code in extended, transparent in standard.
//- size responses never use the internal address bus.
//- extended internal address bits 1:0 encode the byte enables.
//- every 8-bit access places data on lanes D0-D7.
//- 16-bit accesses use even lane D0-D7 and odd lane D8-D15.
//- in an 8-bit backplane odd bytes of wide devices take swap path.
//- steering uses device width and strap; strap matters only in standard mode.
//- device width is driven per access, or tied for uniform devices.
//- extended size response is returned by the START clock edge.
`include "iofe_defs.svh"
module iofe_front_end
  import iofe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic eaMode,
  input wire logic slotDecodeJumper,
  input wire logic wideBackplaneStrapN,
  input wire logic wideDeviceN,
  input wire logic localDmaAckN,
  input wire logic [15:4] boardBase,
  input wire logic [15:0] addr,
  input wire logic [3:0] beN,
  input wire logic iorqN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic bheN,
  input wire logic startN,
  input wire logic cmdN,
  input wire logic mIo,
  input wire logic wR,
  input wire logic aenN,
  output logic rdEvenN,
  output logic wrEvenN,
  output logic rdOddN,
  output logic wrOddN,
  output logic dataDir,
  output logic low_lane_buffer_oe_n,
  output logic high_lane_buffer_oe_n,
  output logic swap_buffer_oe_n,
  output logic ctlOe,
  output logic board_selected_n,
  output logic address_match_n,
  output logic [7:0] internal_address_bus,
  output logic address_latch_enable,
  output logic ex8N,
  output logic ex16N,
  output logic io16N,
  output logic baseIllegal
);
  // =========================================
  // registers
  iofe_cyc_t cycR, cycNxt;
  logic selLatR, selLatNxt;
  logic [7:0] iabR, iabNxt;
  logic [3:0] beLatR, beLatNxt;
  logic rdEvenNR, wrEvenNR, rdOddNR, wrOddNR;
  logic dataDirR, lowOeNR, highOeNR, swapOeNR, ctlOeR;
  logic bdSelNR, matchNR, aleR, ex8NR, ex16NR, io16NR, badBaseR;

  // =========================================
  // decode
  logic saHit, eaHit, baseLegal;
  iofe_board_decode uDecode (
    .addr(addr),
    .boardBase(boardBase),
    .slotMode(slotDecodeJumper),
    .aenN(aenN),
    .mIo(mIo),
    .saHit(saHit),
    .eaHit(eaHit),
    .baseLegal(baseLegal)
  );

  wire saSel = saHit && !iorqN;
  wire startLow = eaMode && !startN;
  wire anyHit = eaMode ? eaHit : saHit;

  // =========================================
  // extended cycle state
  always_comb begin
    cycNxt = cycR;
    case (cycR)
      CYC_IDLE: begin
        if (startLow) cycNxt = CYC_ADDR;
      end
      CYC_ADDR: begin
        if (!cmdN) cycNxt = CYC_CMD;
      end
      CYC_CMD: begin
        if (cmdN) cycNxt = startLow ? CYC_ADDR : CYC_IDLE;
      end
      default: cycNxt = CYC_IDLE;
    endcase
    if (!eaMode) cycNxt = CYC_IDLE;
  end

  // select and address stay put until the next START, so CMD sees a stable value
  assign selLatNxt = startLow ? eaHit : selLatR;
  assign iabNxt = !eaMode ? addr[7:0]
    : startLow ? {addr[7:2], beToLow2(beN)} : iabR;
  // byte enables pipeline to the next address during CMD, so keep the START copy
  assign beLatNxt = startLow ? beN : beLatR;

  // =========================================
  // commands
  wire eaCmd = eaMode && !cmdN && (cycR != CYC_IDLE) && selLatR;
  wire eaRd = eaCmd && !wR;
  wire eaWr = eaCmd && wR;
  wire eaEven = !beLatR[0] || !beLatR[2];
  wire eaOdd = !beLatR[1] || !beLatR[3];
  wire saRd = !eaMode && saSel && !rdN;
  wire saWr = !eaMode && saSel && !wrN;
  wire saEven = !addr[0];
  wire saOdd = addr[0] || !bheN;
  wire busRd = eaRd || saRd;
  wire busWr = eaWr || saWr;
  wire even = eaMode ? eaEven : saEven;
  wire odd = eaMode ? eaOdd : saOdd;
  wire active = busRd || busWr;

  // =========================================
  // lane steering
  logic lowEn, highEn, swapEn;
  iofe_lane_steer uSteer (
    .eaMode(eaMode),
    .wideDeviceN(wideDeviceN),
    .wideBackplaneStrapN(wideBackplaneStrapN),
    .a0(addr[0]),
    .bheN(bheN),
    .beN(beLatR),
    .lowEn(lowEn),
    .highEn(highEn),
    .swapEn(swapEn)
  );

  // =========================================
  // size replies: from decode, START and device width only, never the latched bus
  wire eaSize = eaMode && eaHit && !startN;
  wire saSize = !eaMode && saSel && !wideDeviceN;

  // =========================================
  // flops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cycR <= CYC_IDLE;
      selLatR <= 1'b0;
      iabR <= `IOFE_IAB_RST;
      beLatR <= `IOFE_BE_RST;
    end else begin
      cycR <= cycNxt;
      selLatR <= selLatNxt;
      iabR <= iabNxt;
      beLatR <= beLatNxt;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdEvenNR <= `IOFE_STB_RST;
      wrEvenNR <= `IOFE_STB_RST;
      rdOddNR <= `IOFE_STB_RST;
      wrOddNR <= `IOFE_STB_RST;
    end else begin
      rdEvenNR <= !(busRd && even);
      wrEvenNR <= !(busWr && even);
      rdOddNR <= !(busRd && odd);
      wrOddNR <= !(busWr && odd);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataDirR <= `IOFE_DIR_RST;
      lowOeNR <= `IOFE_STB_RST;
      highOeNR <= `IOFE_STB_RST;
      swapOeNR <= `IOFE_STB_RST;
      ctlOeR <= `IOFE_OE_RST;
    end else begin
      dataDirR <= busRd;
      lowOeNR <= !(active && lowEn);
      highOeNR <= !(active && highEn);
      swapOeNR <= !(active && swapEn);
      ctlOeR <= localDmaAckN;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bdSelNR <= 1'b1;
      matchNR <= 1'b1;
      aleR <= 1'b0;
      ex8NR <= 1'b1;
      ex16NR <= 1'b1;
      io16NR <= 1'b1;
      badBaseR <= 1'b0;
    end else begin
      bdSelNR <= !(eaMode ? selLatNxt : saSel);
      matchNR <= !anyHit;
      aleR <= !eaMode || startLow;
      ex8NR <= !(eaSize && wideDeviceN);
      ex16NR <= !(eaSize && !wideDeviceN);
      io16NR <= !saSize;
      badBaseR <= !slotDecodeJumper && !baseLegal;
    end
  end

  // =========================================
  // outputs
  assign rdEvenN = rdEvenNR;
  assign wrEvenN = wrEvenNR;
  assign rdOddN = rdOddNR;
  assign wrOddN = wrOddNR;
  assign dataDir = dataDirR;
  assign low_lane_buffer_oe_n = lowOeNR;
  assign high_lane_buffer_oe_n = highOeNR;
  assign swap_buffer_oe_n = swapOeNR;
  assign ctlOe = ctlOeR;
  assign board_selected_n = bdSelNR;
  assign address_match_n = matchNR;
  assign internal_address_bus = iabR;
  assign address_latch_enable = aleR;
  assign ex8N = ex8NR;
  assign ex16N = ex16NR;
  assign io16N = io16NR;
  assign baseIllegal = badBaseR;

  // =========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_dma_release: assert property (
    !localDmaAckN |=> !ctlOe)
    else $error("control still driven under DMA acknowledge");

  chk_sa_select: assert property (
    !eaMode && !iorqN && (addr[15:4] == boardBase) |=> !board_selected_n)
    else $error("standard select missing");

  chk_sa_no_iorq: assert property (
    !eaMode && iorqN |=> board_selected_n && rdEvenN && wrEvenN)
    else $error("standard access without I/O request");

  chk_ea_hold: assert property (
    eaMode && startN && $past(eaMode) |=> $stable(internal_address_bus))
    else $error("latched address moved without START");

  chk_ea_strobe: assert property (
    eaMode && !cmdN && !selLatR |=> rdEvenN && rdOddN && wrEvenN && wrOddN)
    else $error("extended strobe without latched select");

  chk_ea_write: assert property (
    eaCmd && wR && !beLatR[0] |=> !wrEvenN && rdEvenN)
    else $error("extended write strobe wrong");

  chk_sa_transp: assert property (
    !eaMode |=> internal_address_bus == $past(addr[7:0]))
    else $error("standard address not transparent");

  chk_be_encode: assert property (
    startLow && (beN == 4'hB) |=> internal_address_bus[1:0] == 2'h2)
    else $error("byte enable encoding wrong");

  chk_swap_lane: assert property (
    !eaMode && saRd && !wideDeviceN && addr[0] && wideBackplaneStrapN
    |=> !swap_buffer_oe_n && high_lane_buffer_oe_n)
    else $error("odd byte not swapped on narrow backplane");

  chk_narrow_low: assert property (
    active && wideDeviceN |=> !low_lane_buffer_oe_n && swap_buffer_oe_n
      ##1 1'b1)
    else $error("8-bit access left low lane");

  chk_ea_strap: assert property (
    eaCmd && !wideDeviceN && beLatR[0] && !beLatR[1]
    |=> !high_lane_buffer_oe_n && swap_buffer_oe_n)
    else $error("strap affected extended steering");

  chk_ea_size: assert property (
    eaMode && eaHit && !startN && wideDeviceN |=> !ex8N && ex16N)
    else $error("size reply missing at START");

  chk_slot_a98: assert property (
    eaMode && slotDecodeJumper && (addr[9:8] != 2'h0) |=> address_match_n)
    else $error("slot decode accepted A8/A9 high");

  chk_ea_both_lanes: assert property (
    eaCmd && !wideDeviceN && !beLatR[0] && !beLatR[1]
    |=> !low_lane_buffer_oe_n && !high_lane_buffer_oe_n)
    else $error("wide extended access missed a lane");

  chk_ea_mem_skip: assert property (
    eaMode && !startN && mIo |=> board_selected_n && ex8N && ex16N)
    else $error("memory cycle selected an I/O board");

  chk_base_flag: assert property (
    !slotDecodeJumper && (boardBase[9:8] == 2'h0) |=> baseIllegal)
    else $error("base outside legacy pages not flagged");

  chk_sa_io16: assert property (
    !eaMode && saSel && !wideDeviceN |=> !io16N)
    else $error("wide standard access without size reply");

  chk_sel_hold: assert property (
    eaMode && startN && $past(eaMode) |=> $stable(board_selected_n))
    else $error("latched select moved without START");

  chk_dma_back: assert property (
    localDmaAckN |=> ctlOe)
    else $error("control not taken back after DMA acknowledge");

  chk_sa_odd_high: assert property (
    saRd && !wideDeviceN && addr[0] && !wideBackplaneStrapN
    |=> !high_lane_buffer_oe_n && swap_buffer_oe_n)
    else $error("odd byte not on high lane");

  chk_ea_read_dir: assert property (
    eaRd |=> dataDir)
    else $error("extended read without read direction");

  cov_sa_wide_read: cover property (
    saRd && !wideDeviceN ##1 !rdOddN && !rdEvenN);
  cov_ea_cycle: cover property (
    startLow && eaHit ##1 cycR == CYC_ADDR ##[1:4] !wrEvenN);
  cov_dma: cover property (!localDmaAckN ##1 !ctlOe);
  cov_slot_hit: cover property (
    eaMode && slotDecodeJumper && !aenN && eaHit ##1 !board_selected_n);
  cov_swap: cover property (active && swapEn ##1 !swap_buffer_oe_n);
endmodule : iofe_front_end

// ### rtl/iofe_defs.svh
`ifndef IOFE_DEFS_SVH
`define IOFE_DEFS_SVH
// =========================================
// address decode fields
`define IOFE_SA_LSB 4
`define IOFE_SLOT_A98 2'h0
`define IOFE_BAD_A1110 2'h3
`define IOFE_BAD_A98 2'h0
// =========================================
// reset values
`define IOFE_STB_RST 1'b1
`define IOFE_OE_RST 1'b0
`define IOFE_IAB_RST 8'h00
`define IOFE_BE_RST 4'hF
`define IOFE_DIR_RST 1'b0
`endif

// ### rtl/iofe_pkg.sv
package iofe_pkg;
  // =========================================
  // extended-mode cycle tracking
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_ADDR,
    CYC_CMD
  } iofe_cyc_t;

  // lowest enabled byte gives address bits 1:0
  function automatic logic [1:0] beToLow2(input logic [3:0] beN);
    logic [1:0] r;
    r = 2'h3;
    if (!beN[0]) r = 2'h0;
    else if (!beN[1]) r = 2'h1;
    else if (!beN[2]) r = 2'h2;
    return r;
  endfunction : beToLow2
endpackage : iofe_pkg

// ### rtl/iofe_board_decode.sv
`include "iofe_defs.svh"
module iofe_board_decode
  import iofe_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [15:4] boardBase,
  input wire logic slotMode,
  input wire logic aenN,
  input wire logic mIo,
  output logic saHit,
  output logic eaHit,
  output logic baseLegal
);
  // =========================================
  // standard: A4-A15 compare, 16 locations
  assign saHit = (addr[15:`IOFE_SA_LSB] == boardBase[15:`IOFE_SA_LSB]);
  // slot space ignores A12-A15, forces A8/A9 low
  wire slotHit = (addr[9:8] == `IOFE_SLOT_A98) && !aenN
    && (addr[11:10] == boardBase[11:10]) && (addr[7:4] == boardBase[7:4]);
  // I/O board: only A0-A15, M-IO low and, in slot mode, the slot enable take part
  assign eaHit = !mIo && (slotMode ? slotHit : saHit);
  // legacy masters: base must sit in a y1-y3, y5-y7 or y9-yB page
  assign baseLegal = (boardBase[9:8] != `IOFE_BAD_A98)
    && (boardBase[11:10] != `IOFE_BAD_A1110);
endmodule : iofe_board_decode

// ### rtl/iofe_lane_steer.sv
module iofe_lane_steer
  import iofe_pkg::*;
(
  input wire logic eaMode,
  input wire logic wideDeviceN,
  input wire logic wideBackplaneStrapN,
  input wire logic a0,
  input wire logic bheN,
  input wire logic [3:0] beN,
  output logic lowEn,
  output logic highEn,
  output logic swapEn
);
  // =========================================
  // lane choice per access
  wire wide = !wideDeviceN;
  wire eaEven = !beN[0] || !beN[2];
  wire eaOdd = !beN[1] || !beN[3];
  wire saBoth = !a0 && !bheN;
  wire eaBoth = eaEven && eaOdd;
  wire both = wide && (eaMode ? eaBoth : saBoth);
  // byte 3 is an odd byte too, so it must land on the high lane
  wire oddOnly = wide && !both && (eaMode ? eaOdd : a0);
  // strap only counts in standard mode
  wire narrowBp = !eaMode && wideBackplaneStrapN;
  assign lowEn = !wide || both || (!oddOnly);
  assign highEn = both || (oddOnly && !narrowBp);
  assign swapEn = oddOnly && narrowBp;
endmodule : iofe_lane_steer

// ### test/iofe_host_model.sv
module iofe_host_model (
  input wire logic ref_clk,
  output logic [15:0] addr,
  output logic [3:0] beN,
  output logic iorqN,
  output logic rdN,
  output logic wrN,
  output logic bheN,
  output logic startN,
  output logic cmdN,
  output logic mIo,
  output logic wR,
  output logic aenN
);
  timeunit 1ns;
  timeprecision 1ns;

  // released address, M-IO and W-R lines show the inverse of the last value, strobes and enables go high
  task automatic idle;
    addr = ~addr;
    beN = 4'hF;
    iorqN = 1'h1;
    rdN = 1'h1;
    wrN = 1'h1;
    bheN = 1'h1;
    startN = 1'h1;
    cmdN = 1'h1;
    mIo = ~mIo;
    wR = ~wR;
    aenN = 1'h1;
  endtask : idle

  task automatic saOn(input logic [15:0] a, input logic w, input logic bhe, input logic iorq);
    @(negedge ref_clk);
    addr = a;
    bheN = bhe;
    iorqN = iorq;
    rdN = w;
    wrN = ~w;
    @(negedge ref_clk);
  endtask : saOn

  task automatic eaOn(input logic [15:0] a, input logic [3:0] be, input logic w,
                      input logic io, input logic aen);
    @(negedge ref_clk);
    addr = a;
    beN = be;
    wR = w;
    mIo = io;
    aenN = aen;
    startN = 1'h0;
    @(negedge ref_clk);
    startN = 1'h1;
    cmdN = 1'h0;
    // next address already pipelined onto the bus
    addr = ~a;
    beN = ~be;
  endtask : eaOn

  initial begin
    addr = 16'h0000;
    mIo = 1'h0;
    wR = 1'h0;
    idle();
  end
endmodule : iofe_host_model

// ### test/test_iofe_front_end.sv
module test_iofe_front_end
  import iofe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic eaMode = 1'h0;
  logic slotDecodeJumper = 1'h0;
  logic wideBackplaneStrapN = 1'h0;
  logic wideDeviceN = 1'h1;
  logic localDmaAckN = 1'h1;
  logic [15:4] boardBase = 12'h050;
  logic [15:0] addr;
  logic [3:0] beN;
  logic iorqN, rdN, wrN, bheN, startN, cmdN, mIo, wR, aenN;
  logic rdEvenN, wrEvenN, rdOddN, wrOddN, dataDir, ctlOe, ex8N, ex16N, io16N;
  logic low_lane_buffer_oe_n, high_lane_buffer_oe_n, swap_buffer_oe_n, baseIllegal;
  logic board_selected_n, address_match_n, address_latch_enable;
  logic [7:0] internal_address_bus;
  logic [11:0] ctl;
  int fails = 0;
  int samples_checked = 0;

  assign ctl = {rdEvenN, wrEvenN, rdOddN, wrOddN, dataDir, low_lane_buffer_oe_n,
                high_lane_buffer_oe_n, swap_buffer_oe_n, board_selected_n, io16N, ex8N, ex16N};

  iofe_front_end i_iofe_front_end (.*);
  iofe_host_model i_iofe_host_model (.*);

  always #20 ref_clk = ~ref_clk;

  // =========================================
  // checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // =========================================
  // transfers
  task automatic saCase(input logic [15:0] a, input logic w, input logic bhe, input logic iorq,
                        input logic [11:0] exp);
    i_iofe_host_model.saOn(a, w, bhe, iorq);
    chk(ctl, exp);
    chk(internal_address_bus, a[7:0]);
    chk({address_match_n, address_latch_enable}, {a[15:4] != boardBase, 1'b1});
    i_iofe_host_model.idle();
    @(negedge ref_clk);
    chk(ctl, 12'hF7F);
  endtask : saCase

  task automatic eaCase(input logic [15:0] a, input logic [3:0] be, input logic w, input logic io,
                        input logic aen, input logic [7:0] bus, input logic [2:0] ex,
                        input logic [7:0] stb);
    i_iofe_host_model.eaOn(a, be, w, io, aen);
    chk({board_selected_n, ex8N, ex16N}, ex);
    chk({address_match_n, address_latch_enable}, {ex[2], 1'b1});
    chk(internal_address_bus, bus);
    @(negedge ref_clk);
    chk(ctl[11:4], stb);
    chk(internal_address_bus, bus);
    chk(address_latch_enable, 1'h0);
    i_iofe_host_model.idle();
    @(negedge ref_clk);
    chk(ctl[11:4], 8'hF7);
  endtask : eaCase

  // hang guard: the whole sequence needs about 80 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    chk(ctl, 12'hF7F);
    chk({ctlOe, address_latch_enable, baseIllegal, internal_address_bus}, 11'h000);
    sys_rst = 1'h0;
    @(negedge ref_clk);
    chk(ctlOe, 1'h1);
    saCase(16'h0506, 1'h0, 1'h1, 1'h0, 12'h7B7);
    saCase(16'h050A, 1'h1, 1'h1, 1'h0, 12'hB37);
    saCase(16'h0516, 1'h0, 1'h1, 1'h0, 12'hF7F);
    saCase(16'h0506, 1'h0, 1'h1, 1'h1, 12'hF7F);
    saCase(16'h0503, 1'h0, 1'h1, 1'h0, 12'hDB7);
    wideDeviceN = 1'h0;
    saCase(16'h0500, 1'h0, 1'h0, 1'h0, 12'h593);
    saCase(16'h0501, 1'h0, 1'h0, 1'h0, 12'hDD3);
    wideBackplaneStrapN = 1'h1;
    saCase(16'h0501, 1'h0, 1'h0, 1'h0, 12'hDE3);
    // =========================================
    // dma acknowledge hands the controls over
    localDmaAckN = 1'h0;
    i_iofe_host_model.saOn(16'h0506, 1'h0, 1'h1, 1'h0);
    chk({ctlOe, board_selected_n}, 2'h0);
    i_iofe_host_model.idle();
    localDmaAckN = 1'h1;
    @(negedge ref_clk);
    chk(ctlOe, 1'h1);
    // =========================================
    // extended transfers, strap left high on purpose
    eaMode = 1'h1;
    wideDeviceN = 1'h1;
    eaCase(16'h0504, 4'hE, 1'h1, 1'h0, 1'h1, 8'h04, 3'h1, 8'hB3);
    eaCase(16'h0508, 4'hB, 1'h0, 1'h0, 1'h1, 8'h0A, 3'h1, 8'h7B);
    wideDeviceN = 1'h0;
    eaCase(16'h050C, 4'hC, 1'h0, 1'h0, 1'h1, 8'h0C, 3'h2, 8'h59);
    eaCase(16'h0500, 4'hD, 1'h1, 1'h0, 1'h1, 8'h01, 3'h2, 8'hE5);
    eaCase(16'h0504, 4'h7, 1'h1, 1'h0, 1'h1, 8'h07, 3'h2, 8'hE5);
    eaCase(16'h0500, 4'hE, 1'h0, 1'h1, 1'h1, 8'h00, 3'h7, 8'hF7);
    slotDecodeJumper = 1'h1;
    boardBase = 12'h045;
    wideDeviceN = 1'h1;
    eaCase(16'h7450, 4'hE, 1'h0, 1'h0, 1'h0, 8'h50, 3'h1, 8'h7B);
    eaCase(16'h7450, 4'hE, 1'h0, 1'h0, 1'h1, 8'h50, 3'h7, 8'hF7);
    eaCase(16'h7750, 4'hE, 1'h0, 1'h0, 1'h0, 8'h50, 3'h7, 8'hF7);
    // =========================================
    // base placement without slot enables
    slotDecodeJumper = 1'h0;
    boardBase = 12'h040;
    repeat (2) @(negedge ref_clk);
    chk(baseIllegal, 1'h1);
    boardBase = 12'h950;
    repeat (2) @(negedge ref_clk);
    chk(baseIllegal, 1'h0);
    report_and_stop();
  end
endmodule : test_iofe_front_end
